// [dpot_map.svh]
// Constants for the dual pot serial command decoder and its host.
// Assumes a 10 MHz system clock on both ends.
`ifndef DPOT_MAP_SVH
`define DPOT_MAP_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define DPOT_TYPE_ID 4'h5
`define DPOT_OP_RD_WIPER 4'h9
`define DPOT_OP_WR_WIPER 4'ha
`define DPOT_OP_RD_STORE 4'hb
`define DPOT_OP_WR_STORE 4'hc
`define DPOT_OP_RECALL 4'hd
`define DPOT_OP_SAVE 4'he
`define DPOT_OP_GRECALL 4'h1
`define DPOT_OP_GSAVE 4'h8
`define DPOT_OP_STEP 4'h2
`define DPOT_OP_STATUS 4'h5

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define DPOT_STORED_RESET 6'h00
`define DPOT_CLK_NS 100
`define DPOT_NV_WRITE_US 5000
`define DPOT_NV_WRITE_CYC (`DPOT_NV_WRITE_US * 1000 / `DPOT_CLK_NS)
`define DPOT_WIPER_RESP_NS 5000
`define DPOT_WIPER_RESP_CYC (`DPOT_WIPER_RESP_NS / `DPOT_CLK_NS)
`define DPOT_SCK_HALF_NS 400
`define DPOT_SCK_HALF_CYC (`DPOT_SCK_HALF_NS / `DPOT_CLK_NS)

// ----------------------------------------
// Host command registers
// ----------------------------------------
`define DPOT_REG_CMD 8'h00
`define DPOT_REG_TARGET 8'h04
`define DPOT_REG_RXDATA 8'h08
`define DPOT_REG_STATUS 8'h0c
`define DPOT_CMD_LONG_BIT 16

`endif

// [dpot_pkg.sv]
// Types shared by both ends of the dual pot serial link.
// Assumes nothing beyond a SystemVerilog compiler.
package dpot_pkg;

  // ----------------------------------------
  // Device frame states
  // ----------------------------------------
  typedef enum logic [4:0] {
    DPOT_ST_ADDR = 5'b00001,
    DPOT_ST_INSTR = 5'b00010,
    DPOT_ST_DATA = 5'b00100,
    DPOT_ST_STEP = 5'b01000,
    DPOT_ST_IGNORE = 5'b10000
  } dpot_dev_state_t;

  // ----------------------------------------
  // Host link states
  // ----------------------------------------
  typedef enum logic [5:0] {
    DPOT_H_IDLE = 6'b000001,
    DPOT_H_SETUP = 6'b000010,
    DPOT_H_LOW = 6'b000100,
    DPOT_H_HIGH = 6'b001000,
    DPOT_H_HOLD = 6'b010000,
    DPOT_H_GAP = 6'b100000
  } dpot_host_state_t;

  typedef logic [5:0] dpot_tap_t;

endpackage

// [dpot_if.sv]
// Serial link between the pot device and its host controller.
// The device holds so low while so_oe is low; the host ignores so_oe and reads so through a two-stage synchroniser.
`timescale 1ns/1ns
interface dpot_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;

  // Device end
  modport dev (input sck, input cs_n, input si, output so, output so_oe);
  // Host end
  modport host (output sck, output cs_n, output si, input so);
endinterface

// [dpot_dev.sv]
// Dual pot device: serial command decoder, wiper and stored settings.
// Assumes the link pins arrive asynchronously and are synchronised here.
//
// Implementation choices: the address map and the pin synchronisers.
`timescale 1ns/1ns
`include "dpot_map.svh"
module dpot_dev #(
  parameter int NV_WRITE_CYCLES = `DPOT_NV_WRITE_CYC,
  parameter int RESP_CYCLES = `DPOT_WIPER_RESP_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial link
  dpot_if.dev link,
  // Address straps
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  // Wiper taps and status
  output logic [5:0] wiper_out0,
  output logic [5:0] wiper_out1,
  output logic write_busy_flag
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] sck_sync_ff;
  logic [1:0] cs_sync_ff;
  logic [1:0] si_sync_ff;
  logic [1:0] ahi_sync_ff;
  logic [1:0] alo_sync_ff;
  logic sck_q_ff;
  logic cs_q_ff;
  dpot_pkg::dpot_dev_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] shift_ff;
  logic [7:0] instr_ff;
  logic rd_ff;
  logic [7:0] tx_ff;
  dpot_pkg::dpot_tap_t wiper_position_reg [2];
  dpot_pkg::dpot_tap_t stored_setting_reg [8];
  logic nv_pending_ff;
  logic [31:0] busy_cnt_ff;
  logic [15:0] resp_cnt_ff;
  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  logic cs_rise;
  logic byte_done;
  logic [7:0] in_byte;
  logic [3:0] op;
  logic pot;
  logic [2:0] set_idx;
  logic sel_zero;

  // ----------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------
  // Two stages per pin; only the second stage is looked at
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_sync_ff <= 2'h0;
      cs_sync_ff <= 2'h3;
      si_sync_ff <= 2'h0;
      ahi_sync_ff <= 2'h0;
      alo_sync_ff <= 2'h0;
      sck_q_ff <= 1'b0;
      cs_q_ff <= 1'b1;
    end else begin
      sck_sync_ff <= {sck_sync_ff[0], link.sck};
      cs_sync_ff <= {cs_sync_ff[0], link.cs_n};
      si_sync_ff <= {si_sync_ff[0], link.si};
      ahi_sync_ff <= {ahi_sync_ff[0], addr_pin_hi};
      alo_sync_ff <= {alo_sync_ff[0], addr_pin_lo};
      sck_q_ff <= sck_sync_ff[1];
      cs_q_ff <= cs_sync_ff[1];
    end
  end

  assign cs_act = ~cs_sync_ff[1];
  assign cs_rise = cs_sync_ff[1] & ~cs_q_ff;
  assign sck_rise = sck_sync_ff[1] & ~sck_q_ff & cs_act;
  assign sck_fall = ~sck_sync_ff[1] & sck_q_ff & cs_act;
  assign byte_done = sck_rise && (bit_cnt_ff == 3'h7);
  assign in_byte = {shift_ff, si_sync_ff[1]};
  assign op = in_byte[7:4];
  assign pot = in_byte[0];
  assign set_idx = {in_byte[0], in_byte[3:2]};
  assign sel_zero = (in_byte[3:2] == 2'h0) && !in_byte[1];

  // ----------------------------------------
  // Frame sequencing
  // ----------------------------------------
  // Bits are taken on each rising serial clock while selected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= dpot_pkg::DPOT_ST_ADDR;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 7'h00;
      instr_ff <= 8'h00;
      rd_ff <= 1'b0;
    end else if (!cs_act) begin
      state_ff <= dpot_pkg::DPOT_ST_ADDR;
      bit_cnt_ff <= 3'h0;
      rd_ff <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      shift_ff <= in_byte[6:0];
      if (byte_done) begin
        case (state_ff)
          dpot_pkg::DPOT_ST_ADDR: begin
            // type pattern and address pins must match
            if (in_byte[7:4] == `DPOT_TYPE_ID && in_byte[3:2] == 2'h0 &&
                in_byte[1:0] == {ahi_sync_ff[1], alo_sync_ff[1]}) begin
              state_ff <= dpot_pkg::DPOT_ST_INSTR;
            end else begin
              state_ff <= dpot_pkg::DPOT_ST_IGNORE;
            end
          end
          dpot_pkg::DPOT_ST_INSTR: begin
            instr_ff <= in_byte;
            case (op)
              `DPOT_OP_RD_WIPER, `DPOT_OP_WR_WIPER, `DPOT_OP_RD_STORE,
              `DPOT_OP_WR_STORE: begin
                state_ff <= dpot_pkg::DPOT_ST_DATA;
                rd_ff <= (op == `DPOT_OP_RD_WIPER) || (op == `DPOT_OP_RD_STORE);
              end
              `DPOT_OP_STATUS: begin
                state_ff <= pot ? dpot_pkg::DPOT_ST_DATA : dpot_pkg::DPOT_ST_IGNORE;
                rd_ff <= pot;
              end
              `DPOT_OP_STEP: state_ff <= dpot_pkg::DPOT_ST_STEP;
              // transfers end after the instruction byte
              default: state_ff <= dpot_pkg::DPOT_ST_IGNORE;
            endcase
          end
          dpot_pkg::DPOT_ST_DATA: state_ff <= dpot_pkg::DPOT_ST_IGNORE;
          dpot_pkg::DPOT_ST_STEP: state_ff <= dpot_pkg::DPOT_ST_STEP;
          default: state_ff <= dpot_pkg::DPOT_ST_IGNORE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Wiper and stored setting registers
  // ----------------------------------------
  // Saves are refused while a non-volatile write is still running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        wiper_position_reg[i] <= `DPOT_STORED_RESET;
      end
      for (int i = 0; i < 8; i++) begin
        stored_setting_reg[i] <= `DPOT_STORED_RESET;
      end
    end else if (sck_rise) begin
      case (state_ff)
        dpot_pkg::DPOT_ST_INSTR: begin
          if (bit_cnt_ff == 3'h7) begin
            // recall, save, global recall and global save opcodes
            case (op)
              `DPOT_OP_RECALL: wiper_position_reg[pot] <= stored_setting_reg[set_idx];
              `DPOT_OP_SAVE: begin
                if (!write_busy_flag) begin
                  stored_setting_reg[set_idx] <= wiper_position_reg[pot];
                end
              end
              `DPOT_OP_GRECALL: begin
                if (!pot) begin
                  wiper_position_reg[0] <= stored_setting_reg[{1'b0, in_byte[3:2]}];
                  wiper_position_reg[1] <= stored_setting_reg[{1'b1, in_byte[3:2]}];
                end
              end
              `DPOT_OP_GSAVE: begin
                if (!pot && !write_busy_flag) begin
                  stored_setting_reg[{1'b0, in_byte[3:2]}] <= wiper_position_reg[0];
                  stored_setting_reg[{1'b1, in_byte[3:2]}] <= wiper_position_reg[1];
                end
              end
              default: ;
            endcase
          end
        end
        dpot_pkg::DPOT_ST_DATA: begin
          if (bit_cnt_ff == 3'h7 && in_byte[7:6] == 2'h0) begin
            if (instr_ff[7:4] == `DPOT_OP_WR_WIPER && instr_ff[3:1] == 3'h0) begin
              wiper_position_reg[instr_ff[0]] <= in_byte[5:0];
            end
            if (instr_ff[7:4] == `DPOT_OP_WR_STORE && !write_busy_flag) begin
              stored_setting_reg[{instr_ff[0], instr_ff[3:2]}] <= in_byte[5:0];
            end
          end
        end
        dpot_pkg::DPOT_ST_STEP: begin
          if (instr_ff[3:1] == 3'h0) begin
            // up on high, stop at 63
            if (si_sync_ff[1] && wiper_position_reg[instr_ff[0]] != 6'h3f) begin
              wiper_position_reg[instr_ff[0]] <= wiper_position_reg[instr_ff[0]] + 6'h01;
            end
            // down on low, stop at 0
            if (!si_sync_ff[1] && wiper_position_reg[instr_ff[0]] != 6'h00) begin
              wiper_position_reg[instr_ff[0]] <= wiper_position_reg[instr_ff[0]] - 6'h01;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Read data shifter
  // ----------------------------------------
  // Loaded as the instruction ends; the next falling clock shows bit 7
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ff <= 8'h00;
      link.so <= 1'b0;
      link.so_oe <= 1'b0;
    end else if (!cs_act) begin
      link.so <= 1'b0;
      link.so_oe <= 1'b0;
    end else begin
      if (byte_done && state_ff == dpot_pkg::DPOT_ST_INSTR) begin
        case (op)
          // wiper read, top two bits zero
          `DPOT_OP_RD_WIPER: tx_ff <= sel_zero ? {2'h0, wiper_position_reg[pot]} : 8'h00;
          `DPOT_OP_RD_STORE: tx_ff <= {2'h0, stored_setting_reg[set_idx]};
          `DPOT_OP_STATUS: tx_ff <= {7'h00, write_busy_flag};
          default: tx_ff <= 8'h00;
        endcase
      end else if (sck_fall && state_ff == dpot_pkg::DPOT_ST_DATA && rd_ff) begin
        link.so <= tx_ff[7];
        link.so_oe <= 1'b1;
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Non-volatile write timing
  // ----------------------------------------
  // a save marks a pending write
  // programming starts at chip select rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_pending_ff <= 1'b0;
      busy_cnt_ff <= 32'h0;
      write_busy_flag <= 1'b0;
    end else begin
      if (byte_done && !write_busy_flag &&
          ((state_ff == dpot_pkg::DPOT_ST_INSTR &&
            (op == `DPOT_OP_SAVE || (op == `DPOT_OP_GSAVE && !pot))) ||
           (state_ff == dpot_pkg::DPOT_ST_DATA && in_byte[7:6] == 2'h0 &&
            instr_ff[7:4] == `DPOT_OP_WR_STORE))) begin
        nv_pending_ff <= 1'b1;
      end else if (cs_rise) begin
        nv_pending_ff <= 1'b0;
      end
      if (cs_rise && nv_pending_ff) begin
        write_busy_flag <= 1'b1;
        busy_cnt_ff <= 32'h0;
      end else if (write_busy_flag) begin
        if (busy_cnt_ff == NV_WRITE_CYCLES - 1) begin
          write_busy_flag <= 1'b0;
        end
        busy_cnt_ff <= busy_cnt_ff + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Wiper response delay
  // ----------------------------------------
  // counted from the first mismatch, so steady stepping cannot starve it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wiper_out0 <= `DPOT_STORED_RESET;
      wiper_out1 <= `DPOT_STORED_RESET;
      resp_cnt_ff <= 16'h0;
    end else if (wiper_out0 != wiper_position_reg[0] ||
                 wiper_out1 != wiper_position_reg[1]) begin
      if (resp_cnt_ff == 16'(RESP_CYCLES - 1)) begin
        wiper_out0 <= wiper_position_reg[0];
        wiper_out1 <= wiper_position_reg[1];
        resp_cnt_ff <= 16'h0;
      end else begin
        resp_cnt_ff <= resp_cnt_ff + 16'h1;
      end
    end else begin
      resp_cnt_ff <= 16'h0;
    end
  end

endmodule

// [dpot_host.sv]
// Host controller: AHB-Lite command registers driving the pot serial link.
// Assumes a single AHB-Lite master and one device on the link.
`timescale 1ns/1ns
`include "dpot_map.svh"
module dpot_host #(
  parameter int SCK_HALF = `DPOT_SCK_HALF_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial link
  dpot_if.host link
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  dpot_pkg::dpot_host_state_t state_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [1:0] target_ff;
  logic [7:0] rx_ff;
  logic [23:0] tx_ff;
  logic [4:0] bits_ff;
  logic [4:0] last_ff;
  logic [7:0] div_ff;
  logic [1:0] so_sync_ff;
  logic go;
  logic half_done;

  assign go = wr_pend_ff && wr_addr_ff == `DPOT_REG_CMD &&
              state_ff == dpot_pkg::DPOT_H_IDLE;
  assign half_done = (div_ff == 8'(SCK_HALF - 1));

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Zero wait states; read data is fetched in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_ff <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
      wr_addr_ff <= haddr;
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr)
          `DPOT_REG_TARGET: hrdata <= {30'h0, target_ff};
          `DPOT_REG_RXDATA: hrdata <= {24'h0, rx_ff};
          `DPOT_REG_STATUS: hrdata <= {31'h0, state_ff != dpot_pkg::DPOT_H_IDLE};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // Target address register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_ff <= 2'h0;
    end else if (wr_pend_ff && wr_addr_ff == `DPOT_REG_TARGET) begin
      target_ff <= hwdata[1:0];
    end
  end

  // Serial output from the device is asynchronous to this clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      so_sync_ff <= 2'h0;
    end else begin
      so_sync_ff <= {so_sync_ff[0], link.so};
    end
  end

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  // Mode 0: data set while clock is low, read late in the high phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= dpot_pkg::DPOT_H_IDLE;
      link.sck <= 1'b0;
      link.cs_n <= 1'b1;
      link.si <= 1'b0;
      tx_ff <= 24'h0;
      rx_ff <= 8'h00;
      bits_ff <= 5'h0;
      last_ff <= 5'h0;
      div_ff <= 8'h00;
    end else begin
      div_ff <= (half_done || state_ff == dpot_pkg::DPOT_H_IDLE) ? 8'h00 : div_ff + 8'h01;
      case (state_ff)
        dpot_pkg::DPOT_H_IDLE: begin
          if (go) begin
            // type pattern, zeros, target address
            // Instruction byte goes out before the data byte
            tx_ff <= {`DPOT_TYPE_ID, 2'h0, target_ff, hwdata[7:0], hwdata[15:8]};
            // short frames carry no data byte
            last_ff <= hwdata[`DPOT_CMD_LONG_BIT] ? 5'd23 : 5'd15;
            bits_ff <= 5'h0;
            link.cs_n <= 1'b0;
            link.si <= 1'b0;
            state_ff <= dpot_pkg::DPOT_H_SETUP;
          end
        end
        dpot_pkg::DPOT_H_SETUP: begin
          if (half_done) begin
            link.si <= tx_ff[23];
            state_ff <= dpot_pkg::DPOT_H_LOW;
          end
        end
        dpot_pkg::DPOT_H_LOW: begin
          if (half_done) begin
            link.sck <= 1'b1;
            state_ff <= dpot_pkg::DPOT_H_HIGH;
          end
        end
        dpot_pkg::DPOT_H_HIGH: begin
          if (half_done) begin
            link.sck <= 1'b0;
            rx_ff <= {rx_ff[6:0], so_sync_ff[1]};
            tx_ff <= {tx_ff[22:0], 1'b0};
            link.si <= tx_ff[22];
            bits_ff <= bits_ff + 5'h1;
            state_ff <= (bits_ff == last_ff) ? dpot_pkg::DPOT_H_HOLD : dpot_pkg::DPOT_H_LOW;
          end
        end
        dpot_pkg::DPOT_H_HOLD: begin
          if (half_done) begin
            link.cs_n <= 1'b1;
            link.si <= 1'b0;
            state_ff <= dpot_pkg::DPOT_H_GAP;
          end
        end
        dpot_pkg::DPOT_H_GAP: begin
          if (half_done) begin
            state_ff <= dpot_pkg::DPOT_H_IDLE;
          end
        end
        default: state_ff <= dpot_pkg::DPOT_H_IDLE;
      endcase
    end
  end

endmodule

// [dpot_monitor.sv]
// Checker for the pot serial link between host and device ends.
// Assumes it sits beside the link interface, fed by plain signals.
`timescale 1ns/1ns
`include "dpot_map.svh"
module dpot_monitor #(
  parameter int NV_CYCLES = `DPOT_NV_WRITE_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link and status
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_oe,
  input wire logic write_busy_flag
);
  // ----------------
  // Busy length
  // ----------------
  // Counter, since the write is far too long for a repetition
  logic [15:0] busy_cnt_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_cnt_ff <= 16'h0000;
    end else begin
      busy_cnt_ff <= write_busy_flag ? busy_cnt_ff + 16'h0001 : 16'h0000;
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Frame steps: setup, one clock high phase, gap
  sequence s_setup; !sck [*4]; endsequence
  sequence s_high; sck [*4] ##1 !sck; endsequence
  sequence s_gap; cs_n [*4]; endsequence
  a_sck_idle: assert property (cs_n |-> !sck)
    else $error("sck moved outside a frame");
  a_cs_setup: assert property ($fell(cs_n) |-> s_setup)
    else $error("sck rose too soon after select");
  a_sck_half: assert property ($rose(sck) |-> s_high)
    else $error("sck high phase wrong length");
  a_si_setup: assert property ($rose(sck) |-> $stable(si))
    else $error("si changed at the sampling edge");
  a_gap_hold: assert property ($rose(cs_n) |-> s_gap)
    else $error("select gap too short");
  a_oe_release: assert property ($rose(cs_n) |-> ##[0:4] !so_oe)
    else $error("so still driven after frame end");
  a_oe_in_frame: assert property ($rose(so_oe) |-> !cs_n)
    else $error("so driven outside a frame");
  a_busy_start: assert property ($rose(write_busy_flag) |-> cs_n)
    else $error("write began inside a frame");
  a_busy_length: assert property ($fell(write_busy_flag) |-> busy_cnt_ff == 16'(NV_CYCLES))
    else $error("write busy length wrong");
  a_busy_bound: assert property (write_busy_flag |-> busy_cnt_ff < 16'(NV_CYCLES))
    else $error("write busy overran");
endmodule

// [testbench.sv]
// Testbench: host and device joined by the link, host driven over AHB-Lite.
// Assumes the design files and dpot_map.svh are compiled first.
`timescale 1ns/1ns
`include "dpot_map.svh"
module testbench;
  localparam int NV = 400;
  localparam int RESP = 50;
  // ----------------
  // Signals
  // ----------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, take, write_busy_flag;
  logic addr_pin_hi, addr_pin_lo;
  logic [7:0] haddr;
  logic [1:0] htrans, tgt;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [5:0] wiper_out0, wiper_out1, v, d;
  logic [31:0] exp_q[$];
  int err_count, checks_done, seed;
  wire hready = hreadyout;
  dpot_if link();
  dpot_host dpot_host_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
  dpot_dev #(.NV_WRITE_CYCLES(NV), .RESP_CYCLES(RESP)) dpot_dev_inst(.hclk(hclk),
    .hresetn(hresetn), .link(link), .addr_pin_hi(addr_pin_hi), .addr_pin_lo(addr_pin_lo),
    .wiper_out0(wiper_out0), .wiper_out1(wiper_out1), .write_busy_flag(write_busy_flag));
  dpot_monitor #(.NV_CYCLES(NV)) dpot_monitor_inst(.hclk(hclk), .hresetn(hresetn),
    .sck(link.sck), .cs_n(link.cs_n), .si(link.si), .so_oe(link.so_oe),
    .write_busy_flag(write_busy_flag));
  // Clock at 10 MHz
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ----------------
  // Tasks
  // ----------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read results meet the oldest note as their data phase ends
  always @(posedge hclk) begin
    if (take === 1'b1 && hreadyout === 1'b1) begin
      cmp("hrdata", exp_q.pop_front(), hrdata);
      cmp("hresp", 32'h0, {31'h0, hresp});
    end
  end
  // One single word transfer; address held until hready, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic chk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= dat;
    take <= chk;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    take <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, 32'h0, 1'b1);
  endtask
  // Send one frame, then poll until the host link is idle again
  task automatic cmd(input logic [7:0] ins, input logic [7:0] dat, input logic lng);
    int n;
    ahb(1'b1, `DPOT_REG_CMD, {15'h0, lng, dat, ins}, 1'b0);
    n = 0;
    rd = 32'h1;
    // A three byte frame lasts about 204 cycles, two per poll
    while (rd[0] !== 1'b0 && n < 400) begin
      ahb(1'b0, `DPOT_REG_STATUS, 32'h0, 1'b0);
      n++;
    end
    cmp("link_idle", 32'h0, {31'h0, rd[0]});
  endtask
  task automatic wait_nv;
    for (int k = 0; k < NV + 50 && write_busy_flag !== 1'b0; k++) @(posedge hclk);
    cmp("busy_end", 32'h0, {31'h0, write_busy_flag});
  endtask
  // Late check waits past the wiper response delay
  task automatic wlate(input logic p, input logic [5:0] nw);
    repeat (RESP + 10) @(posedge hclk);
    cmp("wiper", 32'(nw), 32'(p ? wiper_out1 : wiper_out0));
  endtask
  task automatic wchk(input logic p, input logic [5:0] old, input logic [5:0] nw);
    cmp("wiper_now", 32'(old), 32'(p ? wiper_out1 : wiper_out0));
    wlate(p, nw);
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    seed = 96;
    {hsel, hwrite, take, hresetn} = 4'h0;
    haddr = 8'h00;
    htrans = 2'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    err_count = 0;
    checks_done = 0;
    v = 6'($random(seed));
    d = 6'($random(seed));
    tgt = 2'($random(seed));
    {addr_pin_hi, addr_pin_lo} = tgt;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`DPOT_REG_STATUS, 32'h0);
    rdc(8'h10, 32'h0);
    ahb(1'b1, `DPOT_REG_TARGET, {30'h0, tgt}, 1'b0);
    rdc(`DPOT_REG_TARGET, {30'h0, tgt});
    $display("test registers done");
    cmd(8'ha1, {2'b00, v}, 1'b1);
    wchk(1'b1, 6'h00, v);
    cmd(8'ha1, {2'b11, ~v}, 1'b1);
    wchk(1'b1, v, v);
    cmd(8'h91, 8'h00, 1'b1);
    rdc(`DPOT_REG_RXDATA, {26'h0, v});
    $display("test wiper done");
    cmd(8'hc8, {2'b00, d}, 1'b1);
    cmd(8'h51, 8'h00, 1'b1);
    rdc(`DPOT_REG_RXDATA, 32'h1);
    wait_nv;
    cmd(8'h51, 8'h00, 1'b1);
    rdc(`DPOT_REG_RXDATA, 32'h0);
    cmd(8'hb8, 8'h00, 1'b1);
    rdc(`DPOT_REG_RXDATA, {26'h0, d});
    $display("test stored done");
    cmd(8'hd8, 8'h00, 1'b0);
    wchk(1'b0, 6'h00, d);
    cmd(8'he5, 8'h00, 1'b0);
    cmd(8'hc4, 8'h3f, 1'b1);
    wait_nv;
    cmd(8'hb5, 8'h00, 1'b1);
    rdc(`DPOT_REG_RXDATA, {26'h0, v});
    cmd(8'hb4, 8'h00, 1'b1);
    rdc(`DPOT_REG_RXDATA, 32'h0);
    $display("test transfer done");
    cmd(8'h8c, 8'h00, 1'b0);
    wait_nv;
    cmd(8'h10, 8'h00, 1'b0);
    wchk(1'b1, v, 6'h00);
    cmp("wiper0", 32'h0, 32'(wiper_out0));
    cmd(8'h1c, 8'h00, 1'b0);
    wchk(1'b0, 6'h00, d);
    cmp("wiper1", 32'(v), 32'(wiper_out1));
    $display("test global done");
    cmd(8'ha1, 8'h3e, 1'b1);
    wlate(1'b1, 6'h3e);
    cmd(8'h21, 8'hff, 1'b1);
    wlate(1'b1, 6'h3f);
    cmd(8'h21, 8'h00, 1'b1);
    wlate(1'b1, 6'h37);
    cmd(8'ha0, 8'h03, 1'b1);
    cmd(8'h20, 8'h0f, 1'b1);
    wlate(1'b0, 6'h04);
    $display("test step done");
    ahb(1'b1, `DPOT_REG_TARGET, {30'h0, ~tgt}, 1'b0);
    cmd(8'ha0, 8'h15, 1'b1);
    ahb(1'b1, `DPOT_REG_TARGET, {30'h0, tgt}, 1'b0);
    cmd(8'h30, 8'h15, 1'b1);
    wlate(1'b0, 6'h04);
    cmp("busy", 32'h0, 32'(write_busy_flag));
    $display("test ignore done");
    summarize;
  end
  // Watchdog well past the expected run length
  initial begin
    #4000000;
    err_count++;
    summarize;
  end
endmodule
